// ---- core/lbsc_config_regs.v ----
// SMBus slave with configuration, level code and status for the bias block
//
// Contract
// - Byte bit 7 selects standby bank (0) or active bank (1).
// - Each bank holds run bit from byte bit 6, panel bit from bit 5.
// - Standby pin high selects active bank, low selects standby bank.
// - Every written byte loads its low five bits into the level code.
// - Level code survives shutdown and bank changes; only one is kept.
// - Status is returned by the SMBus read-byte transaction.
// - Status bit 7 is supply good and not shut down.
// - Status bits 6 and 5 read zero; bits 4..0 give level code.
// - Shutdown when the selected bank's run bit is zero.
// - Serial interface keeps working in shutdown; writes can restart.
// - Reset clears standby bank, sets active bank, level code 10000.
// - Run one means operating; panel one means panel on.
// - Panel switch pulls low only if supply good and panel bit set.
// - Only the fixed 7-bit address is acknowledged and acted upon.
// - A write is one data byte with no command byte.
// - In shutdown the level output is zero and panel switch floats.
// - Undervoltage lockout resets the level code like power-up.
`timescale 1ns/1ps
`default_nettype none
`include "lbsc_defines.vh"

module lbsc_config_regs (
    input wire clk_sys,
    input wire sys_rst,
    input wire undervoltageLockout,
    input wire smbClkIn,
    input wire smbDataIn,
    output wire smbDataOut,
    output wire smbDataOe_n,
    input wire standbyInput,
    input wire supplyGoodSense,
    output wire panelSwitchOut,
    output wire panelSwitchOe_n,
    output wire [4:0] levelOut,
    output wire powerDown
);
    localparam ST_IDLE = 7'h01;
    localparam ST_ADDR = 7'h02;
    localparam ST_AACK = 7'h04;
    localparam ST_WDAT = 7'h08;
    localparam ST_DACK = 7'h10;
    localparam ST_RDAT = 7'h20;
    localparam ST_MACK = 7'h40;

    // Two-stage synchronisers; only stage two is read by logic
    reg [1:0] sclSync_reg;
    reg [1:0] sdaSync_reg;
    reg [1:0] stbySync_reg;
    reg sclPrev_reg;
    reg sdaPrev_reg;
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            sclSync_reg <= 2'h3;
            sdaSync_reg <= 2'h3;
            stbySync_reg <= 2'h3;
            sclPrev_reg <= 1'b1;
            sdaPrev_reg <= 1'b1;
        end
        else
        begin
            sclSync_reg <= {sclSync_reg[0], smbClkIn};
            sdaSync_reg <= {sdaSync_reg[0], smbDataIn};
            stbySync_reg <= {stbySync_reg[0], standbyInput};
            sclPrev_reg <= sclSync_reg[1];
            sdaPrev_reg <= sdaSync_reg[1];
        end
    end

    wire scl = sclSync_reg[1];
    wire sda = sdaSync_reg[1];
    wire stby = stbySync_reg[1];
    wire sclRise = scl & ~sclPrev_reg;
    wire sclFall = ~scl & sclPrev_reg;
    // Start and stop are SDA edges while SCL stays high
    wire startCond = scl & sclPrev_reg & ~sda & sdaPrev_reg;
    wire stopCond = scl & sclPrev_reg & sda & ~sdaPrev_reg;

    reg [6:0] state_reg;
    reg [6:0] state_next;
    reg [7:0] shift_reg;
    reg [7:0] shift_next;
    reg [3:0] bitCnt_reg;
    reg [3:0] bitCnt_next;
    reg sdaLow_reg;
    reg sdaLow_next;
    reg [1:0] standbyBank_reg;
    reg [1:0] activeBank_reg;
    reg [4:0] levelCode_reg;
    reg wrStrobe;

    // Effective configuration follows the synchronised standby pin
    wire [1:0] selBank = stby ? activeBank_reg : standbyBank_reg;
    wire isShutdown = ~selBank[1];
    wire panelOn = selBank[0] & ~isShutdown;
    wire [7:0] statusByte = {supplyGoodSense & ~isShutdown, 2'h0,
        levelCode_reg};

    // Bit engine: sample on SCL rise, change SDA after SCL fall
    always @*
    begin
        state_next = state_reg;
        shift_next = shift_reg;
        bitCnt_next = bitCnt_reg;
        sdaLow_next = sdaLow_reg;
        wrStrobe = 1'b0;
        // Serial side is never gated by shutdown, so it keeps working
        if (stopCond)
        begin
            state_next = ST_IDLE;
            sdaLow_next = 1'b0;
        end
        else if (startCond)
        begin
            state_next = ST_ADDR;
            bitCnt_next = 4'h0;
            sdaLow_next = 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    sdaLow_next = 1'b0;
                end
                ST_ADDR:
                begin
                    if (sclRise)
                    begin
                        shift_next = {shift_reg[6:0], sda};
                        bitCnt_next = bitCnt_reg + 4'h1;
                    end
                    else if (sclFall && bitCnt_reg == 4'h8)
                    begin
                        if (shift_reg[7:1] == `LBSC_DEV_ADDR)
                        begin
                            sdaLow_next = 1'b1;
                            state_next = ST_AACK;
                        end
                        else
                        begin
                            state_next = ST_IDLE;
                        end
                    end
                end
                ST_AACK:
                begin
                    if (sclFall)
                    begin
                        bitCnt_next = 4'h0;
                        if (shift_reg[0] == `LBSC_RW_READ)
                        begin
                            shift_next = statusByte;
                            sdaLow_next = ~statusByte[7];
                            state_next = ST_RDAT;
                        end
                        else
                        begin
                            sdaLow_next = 1'b0;
                            state_next = ST_WDAT;
                        end
                    end
                end
                ST_WDAT:
                begin
                    if (sclRise)
                    begin
                        shift_next = {shift_reg[6:0], sda};
                        bitCnt_next = bitCnt_reg + 4'h1;
                    end
                    else if (sclFall && bitCnt_reg == 4'h8)
                    begin
                        wrStrobe = 1'b1;
                        sdaLow_next = 1'b1;
                        state_next = ST_DACK;
                    end
                end
                ST_DACK:
                begin
                    // One data byte per write; further bytes not acked
                    if (sclFall)
                    begin
                        sdaLow_next = 1'b0;
                        state_next = ST_IDLE;
                    end
                end
                ST_RDAT:
                begin
                    if (sclFall)
                    begin
                        bitCnt_next = bitCnt_reg + 4'h1;
                        shift_next = {shift_reg[6:0], 1'b1};
                        if (bitCnt_reg == 4'h7)
                        begin
                            sdaLow_next = 1'b0;
                            state_next = ST_MACK;
                        end
                        else
                        begin
                            sdaLow_next = ~shift_reg[6];
                        end
                    end
                end
                ST_MACK:
                begin
                    // Read byte is a single byte; wait for the stop
                    sdaLow_next = 1'b0;
                end
                default:
                begin
                    state_next = ST_IDLE;
                    sdaLow_next = 1'b0;
                end
            endcase
        end
    end

    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state_reg <= ST_IDLE;
            shift_reg <= 8'h00;
            bitCnt_reg <= 4'h0;
            sdaLow_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            bitCnt_reg <= bitCnt_next;
            sdaLow_reg <= sdaLow_next;
        end
    end

    // Configuration banks, returned to reset values (standby 0, active 3) only by reset
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            standbyBank_reg <= `LBSC_STANDBY_RST;
            activeBank_reg <= `LBSC_ACTIVE_RST;
        end
        else if (wrStrobe)
        begin
            if (shift_reg[`LBSC_BANK_BIT])
                activeBank_reg <= shift_reg[`LBSC_RUN_BIT:`LBSC_PANEL_BIT];
            else
                standbyBank_reg <= shift_reg[`LBSC_RUN_BIT:`LBSC_PANEL_BIT];
        end
    end

    // Single level code; lockout also returns it to mid-scale
    always @(posedge clk_sys)
    begin
        if (sys_rst || undervoltageLockout)
            levelCode_reg <= `LBSC_LEVEL_RST;
        else if (wrStrobe)
            levelCode_reg <= shift_reg[`LBSC_LEVEL_MSB:0];
    end

    // Outputs registered so pins stay glitch free
    reg panelPull_reg;
    reg [4:0] levelOut_reg;
    reg powerDown_reg;
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            panelPull_reg <= 1'b0;
            levelOut_reg <= 5'h00;
            powerDown_reg <= 1'b0;
        end
        else
        begin
            panelPull_reg <= supplyGoodSense & panelOn;
            levelOut_reg <= isShutdown ? 5'h00 : levelCode_reg;
            powerDown_reg <= isShutdown;
        end
    end

    // Open-drain pins: output low, enable active low while pulling
    assign smbDataOut = 1'b0;
    assign smbDataOe_n = ~sdaLow_reg;
    assign panelSwitchOut = 1'b0;
    assign panelSwitchOe_n = ~panelPull_reg;
    assign levelOut = levelOut_reg;
    assign powerDown = powerDown_reg;

endmodule // lbsc_config_regs
`default_nettype wire

// ---- core/lbsc_defines.vh ----
// Constants for the LCD bias serial configuration register block
`ifndef LBSC_DEFINES_VH
`define LBSC_DEFINES_VH
`define LBSC_DEV_ADDR 7'h2C
`define LBSC_BANK_BIT 7
`define LBSC_RUN_BIT 6
`define LBSC_PANEL_BIT 5
`define LBSC_LEVEL_MSB 4
`define LBSC_STAT_GOOD_BIT 7
`define LBSC_STANDBY_RST 2'h0
`define LBSC_ACTIVE_RST 2'h3
`define LBSC_LEVEL_RST 5'h10
`define LBSC_RW_READ 1'b1
`endif

// ---- verification/lbsc_config_regs_checker.sv ----
// Port-level assertions for the bias configuration register block
`timescale 1ns/1ps
`default_nettype none
module lbsc_config_regs_checker (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic undervoltageLockout,
    input wire logic smbClkIn,
    input wire logic smbDataIn,
    input wire logic smbDataOut,
    input wire logic smbDataOe_n,
    input wire logic standbyInput,
    input wire logic supplyGoodSense,
    input wire logic panelSwitchOut,
    input wire logic panelSwitchOe_n,
    input wire logic [4:0] levelOut,
    input wire logic powerDown
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    // Open-drain pins may only ever pull low
    property p_od_low;
        smbDataOut == 1'b0 && panelSwitchOut == 1'b0;
    endproperty
    a_od_low: assert property (p_od_low)
        else $error("open-drain level not low");
    property p_rst_float;
        $fell(sys_rst) |-> smbDataOe_n && panelSwitchOe_n;
    endproperty
    a_rst_float: assert property (p_rst_float)
        else $error("pins driven out of reset");
    property p_rst_level;
        $fell(sys_rst) |-> ##[1:3] levelOut == 5'h10;
    endproperty
    a_rst_level: assert property (p_rst_level)
        else $error("level not mid-scale after reset");
    // Active bank powers up running, standby pin assumed high
    property p_rst_run;
        $fell(sys_rst) |-> !powerDown [*3];
    endproperty
    a_rst_run: assert property (p_rst_run)
        else $error("shut down after reset");
    property p_shut_level;
        powerDown [*2] |-> levelOut == 5'h00;
    endproperty
    a_shut_level: assert property (p_shut_level)
        else $error("level not zero in shutdown");
    property p_shut_panel;
        powerDown [*2] |-> panelSwitchOe_n;
    endproperty
    a_shut_panel: assert property (p_shut_panel)
        else $error("panel pulled in shutdown");
    property p_bad_supply;
        !supplyGoodSense [*2] |-> panelSwitchOe_n;
    endproperty
    a_bad_supply: assert property (p_bad_supply)
        else $error("panel pulled without supply good");
    // Data line may change only while the clock line is low
    property p_sda_scl_low;
        $changed(smbDataOe_n) |-> !smbClkIn;
    endproperty
    a_sda_scl_low: assert property (p_sda_scl_low)
        else $error("data drive changed with clock high");
endmodule // lbsc_config_regs_checker
bind lbsc_config_regs lbsc_config_regs_checker lbsc_config_regs_checker_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .smbClkIn(smbClkIn),
    .undervoltageLockout(undervoltageLockout), .smbDataIn(smbDataIn),
    .smbDataOut(smbDataOut), .smbDataOe_n(smbDataOe_n),
    .standbyInput(standbyInput), .supplyGoodSense(supplyGoodSense),
    .panelSwitchOut(panelSwitchOut), .panelSwitchOe_n(panelSwitchOe_n),
    .levelOut(levelOut), .powerDown(powerDown));
`default_nettype wire

// ---- verification/lbsc_smb_host.sv ----
// Behavioural SMBus host that drives the block's serial pins
`timescale 1ns/1ps
`default_nettype none
module lbsc_smb_host (
    input wire logic clk_sys,
    input wire logic sdaLine,
    output var logic sclOut,
    output var logic sdaOut
);
    // Idle bus: clock stands high, data released to the pull-up
    initial
    begin
        sclOut = 1'b1;
        sdaOut = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Each clock half lasts 8 cycles so the block's sampler keeps up
    task automatic bitx(input logic b, output logic r);
        sdaOut <= b;
        tick(4);
        sclOut <= 1'b1;
        tick(4);
        r = sdaLine;
        tick(4);
        sclOut <= 1'b0;
        tick(4);
    endtask
    task automatic xfer(input logic [7:0] d, output logic [7:0] q,
        output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bitx(d[i], r);
            q[i] = r;
        end
        bitx(1'b1, r);
        ack = ~r;
    endtask
    task automatic start_stop(input logic st);
        sdaOut <= 1'b0;
        tick(st ? 8 : 4);
        sclOut <= !st;
        tick(st ? 4 : 8);
        sdaOut <= !st;
        tick(st ? 0 : 8);
    endtask
    // One data byte, no command byte
    task automatic wr(input logic [6:0] a, input logic [7:0] d,
        output logic ok);
        logic [7:0] q;
        logic k1;
        logic k2;
        start_stop(1'b1);
        xfer({a, 1'b0}, q, k1);
        xfer(d, q, k2);
        start_stop(1'b0);
        ok = k1 & k2;
    endtask
    // Read-byte: address, then status with the host's NACK
    task automatic rd(input logic [6:0] a, output logic [7:0] q,
        output logic ok);
        logic nk;
        logic [7:0] x;
        start_stop(1'b1);
        xfer({a, 1'b1}, x, ok);
        xfer(8'hFF, q, nk);
        start_stop(1'b0);
    endtask
endmodule // lbsc_smb_host
`default_nettype wire

// ---- verification/test_lbsc_config_regs.sv ----
// Self-checking bench for the bias configuration register block
`timescale 1ns/1ps
`default_nettype none
`include "lbsc_defines.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module test_lbsc_config_regs;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic undervoltageLockout = 1'b0;
    logic standbyInput = 1'b1;
    logic supplyGoodSense = 1'b1;
    logic smbClk;
    logic hostSda;
    wire sdaLine;
    wire smbDataOut, smbDataOe_n, panelSwitchOut, panelSwitchOe_n;
    wire powerDown;
    wire [4:0] levelOut;
    int errors = 0;
    int n_compared = 0;
    logic [7:0] st;
    logic ok;
    // Pulled-up wire: low whenever either party pulls it
    assign sdaLine = hostSda & (smbDataOe_n | smbDataOut);
    lbsc_config_regs lbsc_config_regs_i (.clk_sys(clk_sys),
        .sys_rst(sys_rst), .undervoltageLockout(undervoltageLockout),
        .smbClkIn(smbClk), .smbDataIn(sdaLine), .smbDataOut(smbDataOut),
        .smbDataOe_n(smbDataOe_n), .standbyInput(standbyInput),
        .supplyGoodSense(supplyGoodSense), .panelSwitchOut(panelSwitchOut),
        .panelSwitchOe_n(panelSwitchOe_n), .levelOut(levelOut),
        .powerDown(powerDown));
    lbsc_smb_host lbsc_smb_host_i (.clk_sys(clk_sys), .sdaLine(sdaLine),
        .sclOut(smbClk), .sdaOut(hostSda));
    initial forever #12.5 clk_sys = ~clk_sys;
    task automatic summarize;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Outputs settle within a few cycles, pin sync included
    task automatic look(input logic pd, input logic [4:0] lv, input logic po);
        repeat (6) @(posedge clk_sys);
        `CHK("powerDown", pd, powerDown)
        `CHK("levelOut", lv, levelOut)
        `CHK("panelSwitchOe_n", po, panelSwitchOe_n)
    endtask
    task automatic wrb(input logic [7:0] d);
        lbsc_smb_host_i.wr(`LBSC_DEV_ADDR, d, ok);
        `CHK("write ack", 1'b1, ok)
    endtask
    task automatic rdb(input logic [7:0] e);
        lbsc_smb_host_i.rd(`LBSC_DEV_ADDR, st, ok);
        `CHK("status", e, st)
    endtask
    // Whole run is near 3000 cycles; a hang is cut off far later
    initial
    begin
        repeat (40000) @(posedge clk_sys);
        errors++;
        summarize();
    end
    initial
    begin
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        look(1'b0, 5'h10, 1'b0);
        rdb(8'h90);
        lbsc_smb_host_i.wr(7'h2D, 8'h07, ok);
        `CHK("foreign ack", 1'b0, ok)
        look(1'b0, 5'h10, 1'b0);
        wrb(8'h0A);
        look(1'b0, 5'h0A, 1'b0);
        standbyInput <= 1'b0;
        look(1'b1, 5'h00, 1'b1);
        rdb(8'h0A);
        wrb(8'h55);
        look(1'b0, 5'h15, 1'b1);
        wrb(8'h9F);
        look(1'b0, 5'h1F, 1'b1);
        standbyInput <= 1'b1;
        look(1'b1, 5'h00, 1'b1);
        wrb(8'hE3);
        look(1'b0, 5'h03, 1'b0);
        supplyGoodSense <= 1'b0;
        look(1'b0, 5'h03, 1'b1);
        rdb(8'h03);
        undervoltageLockout <= 1'b1;
        @(posedge clk_sys);
        undervoltageLockout <= 1'b0;
        look(1'b0, 5'h10, 1'b1);
        rdb(8'h10);
        summarize();
    end
endmodule // test_lbsc_config_regs
`default_nettype wire
